// File: src/rcsc_pkg.sv
// Package with constants and types for the reset and clock-source controller.
//
// Overview of operation
// - Brown-out cannot reset the chip after reset until software enables it.
// - Brown-out raises an interrupt or a system reset, per configuration.
// - Brown-out causes reset only while brownout_reset_enable is set.
// - Brown-out reset acts like the reset pin and holds while the condition lasts.
// - A brown-out reset is recorded in reset_cause_reg for software.
// - Three peripheral soft-reset registers; setting then clearing a bit resets the unit.
// - Soft-reset bit positions match the clock-gating bit positions.
// - A peripheral soft reset asserts every clock-domain reset of that unit.
// - System reset request bit pulses a reset of the whole system, core included.
// - After reset release the core fetches stack pointer, program counter, instruction.
// - Watchdog interrupts on first time-out and requests reset on the second.
// - On first time-out the watchdog reloads from watchdog_reload_value.
// - Watchdog resets only at second zero with interrupt uncleared and reset enabled.
// - regulator_voltage_adjust sets the regulator target between 2.25 V and 2.75 V.
// - The internal_oscillator clocks the chip during and after power-on reset.
// - The clock mux can also pick the PLL and the internal_oscillator divided by four.
// - Only main_osc drives the PLL; bypass=0 selects PLL, bypass=1 code 0 selects main_osc.
// - With bypass, code 1 internal osc, 2 internal osc over four, 3 the 30-kHz osc.
// - With bypass and extended code 7 the real-time oscillator is the system clock.
// - Cause bits persist across resets; power-on clears all but the power-on bit.
// - use_ext_clock_config makes the extended fields override the base ones.
package rcsc_pkg;
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  OFS_POR_BOR     = 4'h0;
  localparam logic [3:0]  OFS_RESET_CAUSE = 4'h1;
  localparam logic [3:0]  OFS_SOFT_RST0   = 4'h2;
  localparam logic [3:0]  OFS_SOFT_RST1   = 4'h3;
  localparam logic [3:0]  OFS_SOFT_RST2   = 4'h4;
  localparam logic [3:0]  OFS_SYS_RESET   = 4'h5;
  localparam logic [3:0]  OFS_WDOG_LOAD   = 4'h6;
  localparam logic [3:0]  OFS_WDOG_CTRL   = 4'h7;
  localparam logic [3:0]  OFS_REGULATOR   = 4'h8;
  localparam logic [3:0]  OFS_RUN_CLK     = 4'h9;
  localparam logic [3:0]  OFS_RUN_CLK_EXT = 4'ha;
  localparam logic [3:0]  OFS_WDOG_VALUE  = 4'hb;
  // Field positions.
  localparam int unsigned BIT_BOR_IRQ_EN  = 0;
  localparam int unsigned BIT_BOR_RST_EN  = 1;
  localparam int unsigned BIT_CAUSE_EXT   = 0;
  localparam int unsigned BIT_CAUSE_POR   = 1;
  localparam int unsigned BIT_CAUSE_BOR   = 2;
  localparam int unsigned BIT_CAUSE_WDOG  = 3;
  localparam int unsigned BIT_CAUSE_SW    = 4;
  localparam int unsigned BIT_SYS_REQ     = 2;
  localparam int unsigned BIT_WDOG_INT_EN = 0;
  localparam int unsigned BIT_WDOG_RST_EN = 1;
  localparam int unsigned BIT_WDOG_INT    = 2;
  localparam int unsigned BIT_BYPASS      = 11;
  localparam int unsigned POS_OSC_SRC     = 4;
  localparam int unsigned POS_OSC_SRC_EXT = 4;
  localparam int unsigned BIT_USE_EXT     = 31;
  localparam int unsigned REGULATOR_VOLTAGE_ADJUST_W          = 6;
  // Reset values.
  localparam logic [31:0] RST_RUN_CLK     = 32'h0000_0810;
  localparam logic [31:0] RST_RUN_CLK_EXT = 32'h0000_0810;
  localparam logic [31:0] RST_WDOG_LOAD   = 32'hffff_ffff;
  localparam logic [5:0]  RST_REGULATOR_VOLTAGE_ADJUST        = 6'h00;
  // Internal reset pulse length for system requests: 1 us at 50 MHz.
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned SYS_RST_NS      = 1000;
  localparam int unsigned SYS_RST_CYC     = (SYS_RST_NS * CLK_MHZ) / 1000;

  typedef enum logic [2:0] {
    RCSC_SRC_PLL    = 3'b000,
    RCSC_SRC_MAIN   = 3'b001,
    RCSC_SRC_INT    = 3'b010,
    RCSC_SRC_INT_D4 = 3'b011,
    RCSC_SRC_LF30K  = 3'b100,
    RCSC_SRC_RTC    = 3'b101
  } rcsc_clk_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } rcsc_bus_t;

  typedef enum logic [1:0] {
    RCSC_BOOT_SP    = 2'b00,
    RCSC_BOOT_PC    = 2'b01,
    RCSC_BOOT_INSTR = 2'b10,
    RCSC_BOOT_RUN   = 2'b11
  } rcsc_boot_t;
endpackage : rcsc_pkg

// File: src/rcsc_top.sv
// Reset combination, reset cause, watchdog, regulator and clock-source selection.
`timescale 1ns/1ps
module rcsc_top (
  // Clock and power-on reset.
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  // Register port.
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Analog status inputs.
  input  wire logic        I_BROWNOUT,
  input  wire logic        I_EXT_RST_N,
  // Reset outputs.
  output logic             O_CORE_RST,
  output logic      [95:0] O_PERIPH_RST,
  output logic      [1:0]  O_BOOT_STEP,
  // Interrupt requests to the processor.
  output logic             O_BOR_IRQ,
  output logic             O_WDOG_IRQ,
  // Regulator and clock selection.
  output logic      [5:0]  O_REGULATOR_VOLTAGE_ADJUST,
  output logic      [2:0]  O_CLK_SEL,
  output logic             O_PLL_REF_MAIN
);
  rcsc_pkg::rcsc_bus_t bus;
  assign bus = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

  // Pin inputs pass two flops before use.
  logic [1:0] bor_sync_q;
  logic [1:0] ext_sync_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bor_sync_q <= 2'b00;
      ext_sync_q <= 2'b11;
    end else begin
      bor_sync_q <= {bor_sync_q[0], I_BROWNOUT};
      ext_sync_q <= {ext_sync_q[0], I_EXT_RST_N};
    end
  end
  wire bor_lvl = bor_sync_q[1];
  wire ext_rst = ~ext_sync_q[1];

  // Write decodes.
  wire wr_porbor  = bus.wr && bus.addr == rcsc_pkg::OFS_POR_BOR;
  wire wr_cause   = bus.wr && bus.addr == rcsc_pkg::OFS_RESET_CAUSE;
  wire wr_srst0   = bus.wr && bus.addr == rcsc_pkg::OFS_SOFT_RST0;
  wire wr_srst1   = bus.wr && bus.addr == rcsc_pkg::OFS_SOFT_RST1;
  wire wr_srst2   = bus.wr && bus.addr == rcsc_pkg::OFS_SOFT_RST2;
  wire wr_sysrst  = bus.wr && bus.addr == rcsc_pkg::OFS_SYS_RESET;
  wire wr_wload   = bus.wr && bus.addr == rcsc_pkg::OFS_WDOG_LOAD;
  wire wr_wctrl   = bus.wr && bus.addr == rcsc_pkg::OFS_WDOG_CTRL;
  wire wr_reg     = bus.wr && bus.addr == rcsc_pkg::OFS_REGULATOR;
  wire wr_rcc     = bus.wr && bus.addr == rcsc_pkg::OFS_RUN_CLK;
  wire wr_run_clock_config_ext    = bus.wr && bus.addr == rcsc_pkg::OFS_RUN_CLK_EXT;

  // Internal system reset: counts down while active, restarted by a software request or a watchdog reset.
  logic [15:0] sys_cnt_q;
  logic        sys_req;
  logic        wdog_fire;
  logic [1:0]  porbor_q;
  wire  bor_rst   = bor_lvl && porbor_q[rcsc_pkg::BIT_BOR_RST_EN];
  wire  hold_rst  = bor_rst || ext_rst;
  assign sys_req  = wr_sysrst && bus.wdata[rcsc_pkg::BIT_SYS_REQ];
  wire  sys_rst   = hold_rst || sys_cnt_q != 16'h0000;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sys_cnt_q <= 16'h0000;
    end else if (sys_req || wdog_fire) begin
      sys_cnt_q <= 16'(rcsc_pkg::SYS_RST_CYC);
    end else if (sys_cnt_q != 16'h0000) begin
      sys_cnt_q <= sys_cnt_q - 16'h0001;
    end
  end

  // Power-on and brown-out control; reset leaves brown-out reset disabled.
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      porbor_q <= 2'b00;
    end else if (wr_porbor) begin
      porbor_q <= bus.wdata[1:0];
    end
  end
  assign O_BOR_IRQ = bor_lvl && porbor_q[rcsc_pkg::BIT_BOR_IRQ_EN]
                     && !porbor_q[rcsc_pkg::BIT_BOR_RST_EN];

  // Reset cause: sticky, set wins over a software clear, power-on keeps only its bit.
  logic [4:0] cause_q;
  logic [4:0] cause_set;
  assign cause_set = {sys_req, wdog_fire, bor_rst, 1'b0, ext_rst};
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cause_q <= 5'h02;
    end else begin
      cause_q <= (cause_q & ~(wr_cause ? ~bus.wdata[4:0] : 5'h00)) | cause_set;
    end
  end

  // Peripheral soft resets; bit positions follow the clock-gating layout.
  logic [95:0] srst_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      srst_q <= 96'h0;
    end else begin
      if (wr_srst0) begin
        srst_q[31:0] <= bus.wdata;
      end
      if (wr_srst1) begin
        srst_q[63:32] <= bus.wdata;
      end
      if (wr_srst2) begin
        srst_q[95:64] <= bus.wdata;
      end
    end
  end
  // One reset line per unit covers all of its clock domains.
  assign O_PERIPH_RST = srst_q | {96{sys_rst}};
  assign O_CORE_RST   = sys_rst;

  // Boot fetch sequence after the internal reset releases.
  rcsc_pkg::rcsc_boot_t boot_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      boot_q <= rcsc_pkg::RCSC_BOOT_SP;
    end else if (sys_rst) begin
      boot_q <= rcsc_pkg::RCSC_BOOT_SP;
    end else begin
      case (boot_q)
        rcsc_pkg::RCSC_BOOT_SP:    boot_q <= rcsc_pkg::RCSC_BOOT_PC;
        rcsc_pkg::RCSC_BOOT_PC:    boot_q <= rcsc_pkg::RCSC_BOOT_INSTR;
        rcsc_pkg::RCSC_BOOT_INSTR: boot_q <= rcsc_pkg::RCSC_BOOT_RUN;
        default:                   boot_q <= rcsc_pkg::RCSC_BOOT_RUN;
      endcase
    end
  end
  assign O_BOOT_STEP = boot_q;

  // Watchdog: first zero raises the interrupt and reloads, second zero resets.
  logic [31:0] wload_q;
  logic [31:0] wcnt_q;
  logic [2:0]  wctrl_q;
  wire  wzero     = wcnt_q == 32'h0;
  wire  wrun      = wctrl_q[rcsc_pkg::BIT_WDOG_INT_EN];
  wire  wint      = wctrl_q[rcsc_pkg::BIT_WDOG_INT];
  assign wdog_fire = wrun && wzero && wint && wctrl_q[rcsc_pkg::BIT_WDOG_RST_EN];
  wire  wint_set  = wrun && wzero && !wint;
  wire  wint_clr  = wr_wctrl && bus.wdata[rcsc_pkg::BIT_WDOG_INT];
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wload_q <= rcsc_pkg::RST_WDOG_LOAD;
      wcnt_q  <= rcsc_pkg::RST_WDOG_LOAD;
      wctrl_q <= 3'b000;
    end else begin
      if (wr_wload) begin
        wload_q <= bus.wdata;
      end
      // The internal reset also resets the watchdog, so a reset that it requested
      // cannot retrigger itself before software gets a chance to run.
      if (sys_rst) begin
        wcnt_q  <= wload_q;
        wctrl_q <= 3'b000;
      end else begin
        if (wr_wload || (wrun && wzero)) begin
          wcnt_q <= wr_wload ? bus.wdata : wload_q;
        end else if (wrun) begin
          wcnt_q <= wcnt_q - 32'h1;
        end
        if (wr_wctrl) begin
          wctrl_q[1:0] <= bus.wdata[1:0];
        end
        // Interrupt flag: write one clears, a new time-out wins.
        wctrl_q[2] <= wint_set || (wint && !wint_clr);
      end
    end
  end
  assign O_WDOG_IRQ = wint;

  // Regulator adjust field.
  logic [5:0] regulator_voltage_adjust_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      regulator_voltage_adjust_q <= rcsc_pkg::RST_REGULATOR_VOLTAGE_ADJUST;
    end else if (wr_reg) begin
      regulator_voltage_adjust_q <= bus.wdata[5:0];
    end
  end
  assign O_REGULATOR_VOLTAGE_ADJUST = regulator_voltage_adjust_q;

  // Run clock configuration; power-on selects the internal oscillator.
  logic [31:0] rcc_q;
  logic [31:0] run_clock_config_ext_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rcc_q  <= rcsc_pkg::RST_RUN_CLK;
      run_clock_config_ext_q <= rcsc_pkg::RST_RUN_CLK_EXT;
    end else begin
      if (wr_rcc) begin
        rcc_q <= bus.wdata;
      end
      if (wr_run_clock_config_ext) begin
        run_clock_config_ext_q <= bus.wdata;
      end
    end
  end
  wire       use_ext = run_clock_config_ext_q[rcsc_pkg::BIT_USE_EXT];
  wire       bypass  = use_ext ? run_clock_config_ext_q[rcsc_pkg::BIT_BYPASS]
                               : rcc_q[rcsc_pkg::BIT_BYPASS];
  wire [2:0] osrc    = use_ext ? run_clock_config_ext_q[rcsc_pkg::POS_OSC_SRC_EXT +: 3]
                               : {1'b0, rcc_q[rcsc_pkg::POS_OSC_SRC +: 2]};
  rcsc_pkg::rcsc_clk_sel_t clk_sel;
  always_comb begin
    if (!bypass) begin
      clk_sel = rcsc_pkg::RCSC_SRC_PLL;
    end else begin
      case (osrc)
        3'h0:    clk_sel = rcsc_pkg::RCSC_SRC_MAIN;
        3'h1:    clk_sel = rcsc_pkg::RCSC_SRC_INT;
        3'h2:    clk_sel = rcsc_pkg::RCSC_SRC_INT_D4;
        3'h3:    clk_sel = rcsc_pkg::RCSC_SRC_LF30K;
        3'h7:    clk_sel = rcsc_pkg::RCSC_SRC_RTC;
        default: clk_sel = rcsc_pkg::RCSC_SRC_INT;
      endcase
    end
  end
  assign O_CLK_SEL      = clk_sel;
  assign O_PLL_REF_MAIN = 1'b1;

  // Read mux, data one cycle after the strobe.
  logic [31:0] rd_mux;
  always_comb begin
    case (bus.addr)
      rcsc_pkg::OFS_POR_BOR:     rd_mux = {30'h0, porbor_q};
      rcsc_pkg::OFS_RESET_CAUSE: rd_mux = {27'h0, cause_q};
      rcsc_pkg::OFS_SOFT_RST0:   rd_mux = srst_q[31:0];
      rcsc_pkg::OFS_SOFT_RST1:   rd_mux = srst_q[63:32];
      rcsc_pkg::OFS_SOFT_RST2:   rd_mux = srst_q[95:64];
      rcsc_pkg::OFS_WDOG_LOAD:   rd_mux = wload_q;
      rcsc_pkg::OFS_WDOG_CTRL:   rd_mux = {29'h0, wctrl_q};
      rcsc_pkg::OFS_REGULATOR:   rd_mux = {26'h0, regulator_voltage_adjust_q};
      rcsc_pkg::OFS_RUN_CLK:     rd_mux = rcc_q;
      rcsc_pkg::OFS_RUN_CLK_EXT: rd_mux = run_clock_config_ext_q;
      rcsc_pkg::OFS_WDOG_VALUE:  rd_mux = wcnt_q;
      default:                   rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RDATA <= 32'h0;
    end else begin
      O_RDATA <= bus.rd ? rd_mux : 32'h0;
    end
  end

  // Checks.
  chk_bor_gated: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bor_lvl && !porbor_q[1] && !ext_rst && sys_cnt_q == 16'h0) |-> !O_CORE_RST)
    else $error("brown-out reset while disabled");
  chk_bor_holds: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bor_lvl && porbor_q[1]) |-> O_CORE_RST && O_PERIPH_RST[0])
    else $error("brown-out reset not held");
  chk_bor_cause: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    bor_rst |=> cause_q[rcsc_pkg::BIT_CAUSE_BOR])
    else $error("brown-out cause not recorded");
  chk_sys_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (sys_req && !hold_rst) |=> O_CORE_RST [*8])
    else $error("system request reset too short");
  chk_soft_release: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (wr_srst0 && bus.wdata[0] == 1'b0 && !sys_rst && sys_cnt_q == 16'h0 && !hold_rst)
    ##1 !sys_rst |-> !O_PERIPH_RST[0])
    else $error("soft reset not released");
  chk_boot_order: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $fell(sys_rst) |-> boot_q == rcsc_pkg::RCSC_BOOT_SP
    ##1 (sys_rst || boot_q == rcsc_pkg::RCSC_BOOT_PC))
    else $error("boot fetch order broken");
  chk_wdog_reload: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (wint_set && !wr_wload) |=> wcnt_q == $past(wload_q))
    else $error("watchdog did not reload");
  chk_wdog_reset: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wdog_fire |-> $past(wint) && wctrl_q[1])
    else $error("watchdog reset without first time-out");
  chk_clk_pll: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !bypass |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_PLL)
    else $error("PLL not selected");
  chk_clk_rtc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bypass && use_ext && osrc == 3'h7) |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_RTC)
    else $error("real-time oscillator not selected");

  // Brown-out, reset pin, reset request, soft reset and boot step checks.
  chk_bor_en_sw: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !wr_porbor |=> $stable(porbor_q))
    else $error("brown-out control changed without a write");
  chk_bor_action: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bor_lvl && porbor_q != 2'b00) |-> (O_BOR_IRQ || O_CORE_RST))
    else $error("brown-out raised neither interrupt nor reset");
  chk_ext_reset: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ext_rst |-> O_CORE_RST && O_PERIPH_RST == {96{1'b1}})
    else $error("reset pin did not reset everything");
  chk_soft_word0: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_srst0 |=> srst_q[31:0] == $past(bus.wdata))
    else $error("soft reset word 0 not stored");
  chk_soft_word1: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_srst1 |=> srst_q[63:32] == $past(bus.wdata))
    else $error("soft reset word 1 not stored");
  chk_soft_word2: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_srst2 |=> srst_q[95:64] == $past(bus.wdata))
    else $error("soft reset word 2 not stored");
  chk_soft_no_core: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ((wr_srst0 || wr_srst1 || wr_srst2) && !sys_rst && !sys_req && !wdog_fire)
    |=> (!O_CORE_RST || hold_rst))
    else $error("soft reset reached the core");
  chk_periph_sys: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    sys_rst |-> O_PERIPH_RST == {96{1'b1}})
    else $error("system reset missed a peripheral");
  chk_sys_length: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    sys_req |=> sys_cnt_q == 16'(rcsc_pkg::SYS_RST_CYC))
    else $error("system reset length not loaded");
  chk_sys_release: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (sys_cnt_q == 16'h0001 && !sys_req && !wdog_fire) |=> (!O_CORE_RST || hold_rst))
    else $error("system reset not released");
  chk_cause_sw: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    sys_req |=> cause_q[rcsc_pkg::BIT_CAUSE_SW])
    else $error("software reset cause not recorded");
  chk_boot_advance: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (!sys_rst && boot_q != rcsc_pkg::RCSC_BOOT_RUN)
    |=> (sys_rst || O_BOOT_STEP == $past(O_BOOT_STEP) + 2'h1))
    else $error("boot step skipped");
  // Watchdog and regulator checks.
  chk_wdog_first: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (wint_set && !sys_rst) |=> O_WDOG_IRQ)
    else $error("watchdog first time-out not flagged");
  chk_wdog_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (wrun && !wzero && !wr_wload && !sys_rst)
    |=> wcnt_q == $past(wcnt_q) - 32'h1)
    else $error("watchdog did not count down");
  chk_wdog_fires: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wdog_fire |=> O_CORE_RST)
    else $error("watchdog reset request ignored");
  chk_wdog_disarm: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    sys_rst |=> !O_WDOG_IRQ && wctrl_q == 3'b000)
    else $error("watchdog left armed during reset");
  chk_regulator_voltage_adjust_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_reg |=> O_REGULATOR_VOLTAGE_ADJUST == $past(bus.wdata[5:0]))
    else $error("regulator adjust not stored");
  // Clock-source selection and reset cause checks.
  chk_clk_main: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bypass && osrc == 3'h0) |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_MAIN)
    else $error("main oscillator not selected");
  chk_clk_int: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bypass && osrc == 3'h1) |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_INT)
    else $error("internal oscillator not selected");
  chk_clk_div4: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bypass && osrc == 3'h2) |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_INT_D4)
    else $error("divided internal oscillator not selected");
  chk_clk_lf: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (bypass && osrc == 3'h3) |-> O_CLK_SEL == rcsc_pkg::RCSC_SRC_LF30K)
    else $error("30-kHz oscillator not selected");
  chk_clk_override: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    use_ext |-> (bypass == run_clock_config_ext_q[rcsc_pkg::BIT_BYPASS]
                 && osrc == run_clock_config_ext_q[rcsc_pkg::POS_OSC_SRC_EXT +: 3]))
    else $error("extended clock fields not used");
  chk_cause_sticky: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !wr_cause |=> (cause_q & $past(cause_q)) == $past(cause_q))
    else $error("reset cause bit lost without a write");

  cov_bor_reset: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) bor_rst);
  cov_wdog_reset: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) wdog_fire);
  cov_sys_req: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) sys_req);
  cov_ext_clk: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) use_ext && bypass);
  cov_wdog_first: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) wint_set);
endmodule : rcsc_top

// File: tb/rcsc_top_test.sv
// Self-checking testbench for the reset and clock-source controller.
`timescale 1ns/1ps
module rcsc_top_test;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
  } rcsc_note_t;
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        bo;
  logic        ext_rst_n;
  logic        core_rst;
  logic [95:0] periph_rst;
  logic [1:0]  boot_step;
  logic        bor_irq;
  logic        wdog_irq;
  logic [5:0]  regulator_voltage_adjust;
  logic [2:0]  clk_sel;
  logic        pll_ref;
  logic        rd_q;
  int          miscompares;
  int          total_checks;
  int          rst_cycles;
  rcsc_note_t  notes[$];
  rcsc_note_t  note;
  logic [31:0] v;
  logic [3:0]  ca [8] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'ha, 4'ha, 4'ha};
  logic [31:0] cd [8] = '{32'h0, 32'h800, 32'h810, 32'h820, 32'h830,
                          32'h8000_0870, 32'h8000_0810, 32'h870};
  logic [2:0]  ce [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h4};

  rcsc_top i_rcsc_top (
    .I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_BROWNOUT(bo), .I_EXT_RST_N(ext_rst_n), .O_CORE_RST(core_rst),
    .O_PERIPH_RST(periph_rst), .O_BOOT_STEP(boot_step), .O_BOR_IRQ(bor_irq),
    .O_WDOG_IRQ(wdog_irq), .O_REGULATOR_VOLTAGE_ADJUST(regulator_voltage_adjust), .O_CLK_SEL(clk_sel), .O_PLL_REF_MAIN(pll_ref)
  );

  always #10 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // The expected word is queued when the read is issued; the monitor compares it.
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    notes.push_back('{exp: e, mask: m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic wait_on(input bit irq, input logic lvl, input int bound);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (((irq ? wdog_irq : core_rst) !== lvl) && n < bound);
    if ((irq ? wdog_irq : core_rst) !== lvl) begin
      miscompares++;
      $display("mismatch wait_level expected %b seen %b", lvl, irq ? wdog_irq : core_rst);
      wrap_up();
    end
  endtask : wait_on

  always @(posedge clk) rd_q <= rd;

  always @(negedge clk) begin
    if (core_rst === 1'b1) rst_cycles++;
    if (rd_q === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("mismatch rdata expected none seen %h", rdata);
      end else begin
        note = notes.pop_front();
        chk("rdata", 96'(note.exp), 96'(rdata & note.mask));
      end
    end
  end

  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    addr       = 4'h0;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    bo         = 1'b0;
    ext_rst_n  = 1'b1;
    rst_cycles = 0;
    v = $urandom(32'he7cd2d58);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("clk_sel", 96'(rcsc_pkg::RCSC_SRC_INT), 96'(clk_sel));
    chk("core_rst", 96'h0, 96'(core_rst));
    chk("pll_ref", 96'h1, 96'(pll_ref));
    chk("regulator_voltage_adjust", 96'(rcsc_pkg::RST_REGULATOR_VOLTAGE_ADJUST), 96'(regulator_voltage_adjust));
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h2, 32'h1f);
    wr_reg(4'hc, $urandom);
    rd_reg(4'hc, 32'h0, 32'hffff_ffff);
    v = 32'($urandom % 64);
    wr_reg(rcsc_pkg::OFS_REGULATOR, v);
    @(negedge clk);
    chk("regulator_voltage_adjust", 96'(v), 96'(regulator_voltage_adjust));
    rd_reg(rcsc_pkg::OFS_REGULATOR, v, 32'h3f);
    for (int i = 0; i < 8; i++) begin
      wr_reg(ca[i], cd[i]);
      @(negedge clk);
      chk("clk_sel", 96'(ce[i]), 96'(clk_sel));
    end
    for (int w = 0; w < 3; w++) begin
      v = 32'h1 << ($urandom % 32);
      wr_reg(rcsc_pkg::OFS_SOFT_RST0 + 4'(w), v);
      @(negedge clk);
      chk("periph_rst", 96'(v) << (32 * w), periph_rst);
      chk("core_rst", 96'h0, 96'(core_rst));
      rd_reg(rcsc_pkg::OFS_SOFT_RST0 + 4'(w), v, 32'hffff_ffff);
      wr_reg(rcsc_pkg::OFS_SOFT_RST0 + 4'(w), 32'h0);
      @(negedge clk);
      chk("periph_rst", 96'h0, periph_rst);
    end
    // A brown-out with both enables clear must be ignored, then raise only the interrupt.
    wr_reg(rcsc_pkg::OFS_POR_BOR, 32'h0);
    bo <= 1'b1;
    repeat (6) @(negedge clk);
    chk("bor_irq", 96'h0, 96'(bor_irq));
    chk("core_rst", 96'h0, 96'(core_rst));
    wr_reg(rcsc_pkg::OFS_POR_BOR, 32'h1);
    @(negedge clk);
    chk("bor_irq", 96'h1, 96'(bor_irq));
    @(posedge clk);
    bo <= 1'b0;
    wr_reg(rcsc_pkg::OFS_POR_BOR, 32'h2);
    repeat (4) @(posedge clk);
    rst_cycles = 0;
    bo <= 1'b1;
    repeat (20) @(posedge clk);
    bo <= 1'b0;
    repeat (6) @(posedge clk);
    chk("bor_hold", 96'd20, 96'(rst_cycles));
    wr_reg(rcsc_pkg::OFS_POR_BOR, 32'h0);
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h6, 32'h1f);
    rst_cycles = 0;
    ext_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    ext_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ext_hold", 96'd10, 96'(rst_cycles));
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h7, 32'h1f);
    wr_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h0);
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h0, 32'h1f);
    rst_cycles = 0;
    wr_reg(rcsc_pkg::OFS_SYS_RESET, 32'h1 << rcsc_pkg::BIT_SYS_REQ);
    wait_on(1'b0, 1'b1, 4);
    chk("periph_rst", {96{1'b1}}, periph_rst);
    wait_on(1'b0, 1'b0, 300);
    for (int i = 0; i < 4; i++) begin
      chk("boot_step", 96'(i), 96'(boot_step));
      @(negedge clk);
    end
    chk("sys_hold", 96'(rcsc_pkg::SYS_RST_CYC), 96'(rst_cycles));
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h10, 32'h1f);
    wr_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h0);
    // The watchdog first runs without its reset output, so a second zero must not reset.
    wr_reg(rcsc_pkg::OFS_WDOG_LOAD, 32'h1e);
    rd_reg(rcsc_pkg::OFS_WDOG_LOAD, 32'h1e, 32'hffff_ffff);
    wr_reg(rcsc_pkg::OFS_WDOG_CTRL, 32'h1);
    wait_on(1'b1, 1'b1, 80);
    rst_cycles = 0;
    repeat (80) @(posedge clk);
    chk("wdog_no_rst", 96'h0, 96'(rst_cycles));
    wr_reg(rcsc_pkg::OFS_WDOG_CTRL, 32'h3);
    wait_on(1'b0, 1'b1, 80);
    wait_on(1'b0, 1'b0, 300);
    chk("wdog_irq", 96'h0, 96'(wdog_irq));
    rd_reg(rcsc_pkg::OFS_WDOG_VALUE, 32'h1e, 32'hffff_ffff);
    rd_reg(rcsc_pkg::OFS_RESET_CAUSE, 32'h8, 32'h1f);
    wr_reg(rcsc_pkg::OFS_WDOG_CTRL, 32'h4);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule : rcsc_top_test
